/* File: design/sfc_flash_if.sv */
// What this block does
// [R1] works with bus mode 0 and mode 3; only clock edges matter
// [R2] sample input on rising serial clock, change output on falling
// [R3] accept 75MHz single lane, 70MHz dual lane serial clock; sampling here limits it to about a quarter of clk_i
// [R4] 128 sectors of 4K bytes, each erasable alone
// [R5] 8 blocks of 64K bytes, sixteen sectors each, each erasable alone
// [R6] program at most one 256-byte page, self-timed, at most 1ms
// [R7] dual read drives both lanes, two bits per clock
// [R8] unknown command: standby, output off, ignore until next select
// [R9] known command: active until chip select rises
// [R10] read commands stream data; host may deselect after any bit
// [R11] write-type commands run only if deselected on a byte boundary
// [R12] array access ignored while a timed operation runs
// [R13] write_in_progress shows program and erase completion
// [R14] deselected and idle means standby
// [R15] reset gives standby and a clear write_enable_latch
// [R16] data-changing commands need write_enable_latch set first
// [R17] latch clears on disable, status write, program and erase completion
// [R18] deep sleep accepts only wake and signature read
// [R19] protect_level_bits fence a region against program and erase
// [R20] host programs only erased pages; no erase before program
// [R21] erase by sector, block or whole array, self-timed
// [R22] command length checked to whole bytes before acceptance
// [R23] bytes travel most significant bit first, command byte first
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/10ps
`include "sfc_params.svh"
module sfc_flash_if #(
   parameter int PROG_CYC = `SFC_T_PROG_US * `SFC_CLK_MHZ,
   parameter int STAT_CYC = `SFC_T_STAT_US * `SFC_CLK_MHZ,
   parameter int SECT_CYC = `SFC_T_SECT_US * `SFC_CLK_MHZ,
   parameter int BLK_CYC  = `SFC_T_BLK_US * `SFC_CLK_MHZ,
   parameter int CE_CYC   = `SFC_T_CE_US * `SFC_CLK_MHZ,
   parameter logic [7:0] MAKER_ID = 8'hA5, // arbitrary value
   parameter logic [7:0] DEV_ID_HI = 8'h5A, // arbitrary value
   parameter logic [7:0] DEV_ID_LO = 8'h3C, // arbitrary value
   parameter logic [7:0] SIG_ID    = 8'hC3  // arbitrary value
) (
   input  wire logic              clk_i,
   input  wire logic              arst_n_i,
   input  wire logic              ce_i,
   input  wire sfc_pkg::sfc_pins_t pins_i,
   output logic                   lane0_o,
   output logic                   lane0_oe_n_o,
   output logic                   lane1_o,
   output logic                   lane1_oe_n_o,
   output logic [18:0]            mem_addr_o,
   input  wire logic [7:0]        mem_rdata_i,
   output logic                   op_start_o,
   output sfc_pkg::sfc_op_t       op_o,
   output logic                   prog_valid_o,
   output sfc_pkg::sfc_prog_t     prog_o,
   output logic                   busy_o,
   input  wire logic [3:0]        reg_addr_i,
   input  wire logic [31:0]       reg_wdata_i,
   input  wire logic              reg_wr_i,
   input  wire logic              reg_rd_i,
   output logic [31:0]            reg_rdata_o
);
   import sfc_pkg::*;

   logic [3:0]  pin_q, pin_r, pin_f;
   sfc_state_t  state_reg;
   sfc_cmd_t    cmd_reg;
   logic [15:0] bit_cnt_reg;
   logic [7:0]  shift_reg;
   logic [23:0] addr_sh_reg;
   logic [18:0] addr_reg;
   logic [7:0]  status_write_cmd_reg;
   logic [7:0]  out_byte_reg;
   logic [2:0]  sub_reg;
   logic [7:0]  idx_reg;
   logic        drive_reg, dual_reg, lane0_reg, lane1_reg;
   logic        wlatch_reg, deep_reg, hw_lock_reg;
   logic [2:0]  bp_reg;
   logic [31:0] op_cnt_reg;
   logic [7:0]  last_reg;
   logic        cs_fall, cs_rise, sck_rise, sck_fall, si;

   sfc_pin_sync #(.W(4)) u_sync (
      .clk_i    (clk_i),
      .arst_n_i (arst_n_i),
      .ce_i     (ce_i),
      .d_i      (pins_i),
      .q_o      (pin_q),
      .rise_o   (pin_r),
      .fall_o   (pin_f)
   );
   assign cs_fall  = pin_f[3];
   assign cs_rise  = pin_r[3];
   assign sck_rise = pin_r[2] && !pin_q[3]; // [R1]
   assign sck_fall = pin_f[2] && !pin_q[3]; // [R1]
   assign si       = pin_q[1];

   ////////////////////////////////////////////////////////////////////////////////
   function automatic sfc_cmd_t decode(input logic [7:0] op);
      case (op)
         `SFC_OP_SETWL: decode = CMD_SETWL;
         `SFC_OP_CLRWL: decode = CMD_CLRWL;
         `SFC_OP_STWR:  decode = CMD_STWR;
         `SFC_OP_STRD:  decode = CMD_STRD;
         `SFC_OP_IDRD:  decode = CMD_IDRD;
         `SFC_OP_READ:  decode = CMD_READ;
         `SFC_OP_FAST:  decode = CMD_FAST;
         `SFC_OP_SFDP:  decode = CMD_SFDP;
         `SFC_OP_DUAL:  decode = CMD_DUAL;
         `SFC_OP_SIG:   decode = CMD_SIG;
         `SFC_OP_MKID:  decode = CMD_MKID;
         `SFC_OP_SECT:  decode = CMD_SECT;
         `SFC_OP_BE1, `SFC_OP_BE2: decode = CMD_BLK;
         `SFC_OP_CE1, `SFC_OP_CE2: decode = CMD_CE;
         `SFC_OP_PROG:  decode = CMD_PROG;
         `SFC_OP_SLEEP: decode = CMD_SLEEP;
         default:       decode = CMD_NONE;
      endcase
   endfunction : decode

   // first serial clock that carries output data
   function automatic logic [15:0] out_start(input sfc_cmd_t c);
      case (c)
         CMD_STRD, CMD_IDRD:           out_start = `SFC_LEN_CMD;
         CMD_READ, CMD_SIG, CMD_MKID:  out_start = `SFC_LEN_ADDR;
         CMD_FAST, CMD_SFDP, CMD_DUAL: out_start = `SFC_LEN_DUMY;
         default:                      out_start = 16'hFFFF;
      endcase
   endfunction : out_start

   function automatic logic blocked(input logic [2:0] bp, input logic [2:0] blk);
      case (bp)
         3'h0:    blocked = 1'b0;
         3'h1:    blocked = (blk == 3'h7);
         3'h2:    blocked = (blk >= 3'h6);
         3'h3:    blocked = (blk >= 3'h4);
         default: blocked = 1'b1;
      endcase
   endfunction : blocked

   ////////////////////////////////////////////////////////////////////////////////
   logic [7:0] cmd_byte;
   sfc_cmd_t   cmd_new;
   logic       busy, accept, is_array, is_write;
   assign busy     = (op_cnt_reg != 32'h0000_0000);
   assign cmd_byte = {shift_reg[6:0], si};
   assign cmd_new  = decode(cmd_byte);
   assign is_array = cmd_new inside {CMD_READ, CMD_FAST, CMD_DUAL, CMD_SFDP};
   assign is_write = cmd_new inside {CMD_SETWL, CMD_CLRWL, CMD_STWR, CMD_SECT, CMD_BLK, CMD_CE, CMD_PROG};
   always_comb begin
      accept = (cmd_new != CMD_NONE); // [R8]
      if (deep_reg && cmd_new != CMD_SIG) accept = 1'b0; // [R18]
      if (busy && (is_array || is_write)) accept = 1'b0; // [R12]
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_reg   <= ST_STANDBY; // [R15]
         cmd_reg     <= CMD_NONE;
         bit_cnt_reg <= 16'h0000;
         shift_reg   <= 8'h00;
         addr_sh_reg <= 24'h00_0000;
      end else if (ce_i) begin
         if (cs_rise) begin
            state_reg <= ST_STANDBY; // [R9] [R14]
         end else if (cs_fall) begin
            state_reg   <= ST_CMD;
            bit_cnt_reg <= 16'h0000;
         end else if (sck_rise && state_reg != ST_IGNORE && state_reg != ST_STANDBY) begin // [R2]
            bit_cnt_reg <= bit_cnt_reg + 16'h0001;
            shift_reg   <= cmd_byte; // [R23]
            addr_sh_reg <= {addr_sh_reg[22:0], si};
            if (state_reg == ST_CMD && bit_cnt_reg == `SFC_LEN_CMD - 16'h0001) begin
               cmd_reg   <= cmd_new;
               state_reg <= accept ? ST_ACTIVE : ST_IGNORE; // [R8] [R9]
            end
         end
      end
   end
   ignore_quiet_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R8]
      state_reg == ST_IGNORE |-> lane1_oe_n_o && lane0_oe_n_o) else $error("output driven after bad command");
   standby_idle_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R14]
      pin_q[3] && $past(pin_q[3]) |-> state_reg == ST_STANDBY) else $error("not standby while deselected");
   sleep_gate_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R18]
      deep_reg && state_reg == ST_ACTIVE |-> cmd_reg == CMD_SIG) else $error("command accepted in deep sleep");

   // address and status byte capture
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         addr_reg <= 19'h0_0000;
         status_write_cmd_reg <= 8'h00;
      end else if (ce_i && sck_rise && state_reg == ST_ACTIVE) begin
         if (bit_cnt_reg == `SFC_LEN_ADDR - 16'h0001)
            addr_reg <= {addr_sh_reg[17:0], si};
         if (bit_cnt_reg == `SFC_LEN_STAT - 16'h0001)
            status_write_cmd_reg <= cmd_byte;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // output side; live status is re-read per byte so polling sees the busy flag drop
   logic [7:0] status_byte, fresh, cur;
   logic       out_phase, last_sub;
   assign status_byte = {3'h0, bp_reg, wlatch_reg, busy}; // [R13]
   assign out_phase   = state_reg == ST_ACTIVE && bit_cnt_reg >= out_start(cmd_reg); // [R10]
   assign last_sub    = dual_reg ? (sub_reg == 3'h3) : (sub_reg == 3'h7);
   always_comb begin
      case (cmd_reg)
         CMD_STRD: fresh = status_byte;
         CMD_IDRD: fresh = (idx_reg == 8'h00) ? MAKER_ID : (idx_reg == 8'h01) ? DEV_ID_HI :
                           (idx_reg == 8'h02) ? DEV_ID_LO : 8'h00;
         CMD_SIG:  fresh = SIG_ID;
         CMD_MKID: fresh = (idx_reg[0] ^ addr_reg[0]) ? DEV_ID_LO : MAKER_ID;
         CMD_SFDP: fresh = `SFC_SFDP_FILL;
         default:  fresh = mem_rdata_i;
      endcase
      cur = (sub_reg == 3'h0) ? fresh : out_byte_reg;
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         drive_reg    <= 1'b0;
         dual_reg     <= 1'b0;
         lane0_reg    <= 1'b0;
         lane1_reg    <= 1'b0;
         sub_reg      <= 3'h0;
         idx_reg      <= 8'h00;
         out_byte_reg <= 8'h00;
         mem_addr_o   <= 19'h0_0000;
      end else if (ce_i) begin
         if (cs_rise || cs_fall) begin
            drive_reg <= 1'b0; // [R10]
            dual_reg  <= 1'b0;
            sub_reg   <= 3'h0;
            idx_reg   <= 8'h00;
         end else if (sck_rise && state_reg == ST_ACTIVE && bit_cnt_reg == `SFC_LEN_ADDR - 16'h0001) begin
            mem_addr_o <= {addr_sh_reg[17:0], si};
         end else if (sck_fall && out_phase) begin // [R2]
            drive_reg    <= 1'b1;
            dual_reg     <= (cmd_reg == CMD_DUAL); // [R7]
            out_byte_reg <= cur;
            sub_reg      <= last_sub ? 3'h0 : sub_reg + 3'h1;
            if (cmd_reg == CMD_DUAL) begin
               lane1_reg <= cur[3'h7 - {sub_reg[1:0], 1'b0}]; // [R7]
               lane0_reg <= cur[3'h6 - {sub_reg[1:0], 1'b0}];
            end else begin
               lane1_reg <= cur[3'h7 - sub_reg]; // [R23]
            end
            if (last_sub) begin
               idx_reg    <= idx_reg + 8'h01;
               mem_addr_o <= mem_addr_o + 19'h0_0001;
            end
         end
      end
   end
   assign lane1_o      = lane1_reg;
   assign lane0_o      = lane0_reg;
   assign lane1_oe_n_o = !drive_reg;
   assign lane0_oe_n_o = !(drive_reg && dual_reg);
   dual_lanes_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R7]
      drive_reg && cmd_reg == CMD_DUAL |-> !lane0_oe_n_o && !lane1_oe_n_o) else $error("dual read one lane");
   deselect_off_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R10]
      ce_i && cs_rise |=> lane1_oe_n_o) else $error("output still driven after deselect");

   ////////////////////////////////////////////////////////////////////////////////
   // execution at deselect; length must land on the byte boundary for write-type commands
   logic       len_ok, go_op;
   sfc_op_t    op_next;
   logic [31:0] cyc_next;
   always_comb begin
      len_ok   = 1'b0;
      go_op    = 1'b0;
      op_next  = '{kind: OP_PROG, chip: 1'b0, addr: addr_reg};
      cyc_next = 32'h0000_0000;
      case (cmd_reg)
         CMD_SETWL, CMD_CLRWL, CMD_SLEEP: len_ok = (bit_cnt_reg == `SFC_LEN_CMD); // [R11] [R22]
         CMD_STWR: begin
            len_ok   = (bit_cnt_reg == `SFC_LEN_STAT);
            go_op    = len_ok && wlatch_reg; // [R16]
            op_next.kind = OP_STAT;
            cyc_next = STAT_CYC;
         end
         CMD_SECT: begin
            len_ok   = (bit_cnt_reg == `SFC_LEN_ADDR);
            go_op    = len_ok && wlatch_reg && !blocked(bp_reg, addr_reg[18:16]); // [R19]
            op_next  = '{kind: OP_ERASE_SECT, chip: 1'b0, addr: addr_reg & `SFC_SECT_MASK}; // [R4] [R21]
            cyc_next = SECT_CYC;
         end
         CMD_BLK: begin
            len_ok   = (bit_cnt_reg == `SFC_LEN_ADDR);
            go_op    = len_ok && wlatch_reg && !blocked(bp_reg, addr_reg[18:16]); // [R19]
            op_next  = '{kind: OP_ERASE_BLK, chip: 1'b0, addr: addr_reg & `SFC_BLK_MASK}; // [R5] [R21]
            cyc_next = BLK_CYC;
         end
         CMD_CE: begin
            len_ok   = (bit_cnt_reg == `SFC_LEN_CMD);
            go_op    = len_ok && wlatch_reg && (bp_reg == 3'h0); // [R19] [R21]
            op_next  = '{kind: OP_ERASE_BLK, chip: 1'b1, addr: 19'h0_0000};
            cyc_next = CE_CYC;
         end
         CMD_PROG: begin
            len_ok   = (bit_cnt_reg >= `SFC_LEN_DUMY) && (bit_cnt_reg[2:0] == 3'h0); // [R11]
            go_op    = len_ok && wlatch_reg && !blocked(bp_reg, addr_reg[18:16]); // [R16] [R19]
            cyc_next = PROG_CYC; // [R6]
         end
         default: len_ok = 1'b1;
      endcase
      if (!(ce_i && cs_rise && state_reg == ST_ACTIVE)) begin
         len_ok = 1'b0;
         go_op  = 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         op_cnt_reg <= 32'h0000_0000;
         op_start_o <= 1'b0;
         op_o       <= '0;
      end else if (ce_i) begin
         op_start_o <= go_op;
         if (go_op) begin
            op_cnt_reg <= cyc_next; // [R6] [R21]
            op_o       <= op_next;
         end else if (busy) begin
            op_cnt_reg <= op_cnt_reg - 32'h0000_0001; // [R13]
         end
      end
   end
   assign busy_o = busy;
   boundary_only_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R11]
      op_start_o |-> $past(bit_cnt_reg[2:0]) == 3'h0 && $past(wlatch_reg)) else $error("operation off byte boundary");
   no_restart_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R12]
      $past(busy) && $past(ce_i) |-> !op_start_o) else $error("operation started while busy");
   fence_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R19]
      op_start_o && op_o.kind != OP_STAT && !op_o.chip |-> !blocked(bp_reg, op_o.addr[18:16]))
      else $error("protected region altered");

   // latch, protect level and sleep state
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wlatch_reg <= 1'b0; // [R15]
         bp_reg     <= 3'h0;
         deep_reg   <= 1'b0;
      end else if (ce_i) begin
         if (len_ok && cmd_reg == CMD_SETWL) wlatch_reg <= 1'b1; // [R16]
         if (len_ok && cmd_reg == CMD_CLRWL) wlatch_reg <= 1'b0; // [R17]
         if (op_cnt_reg == 32'h0000_0001) wlatch_reg <= 1'b0; // [R17]
         if (go_op && cmd_reg == CMD_STWR && !hw_lock_reg) bp_reg <= status_write_cmd_reg[4:2];
         if (len_ok && cmd_reg == CMD_SLEEP) deep_reg <= 1'b1;
         if (len_ok && cmd_reg == CMD_SIG) deep_reg <= 1'b0;
      end
   end
   wel_done_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R17]
      ce_i && op_cnt_reg == 32'h0000_0001 |=> !wlatch_reg && !busy) else $error("latch left set after operation");
   reset_state_a: assert property (@(posedge clk_i) // [R15]
      $rose(arst_n_i) |-> !wlatch_reg && state_reg == ST_STANDBY) else $error("bad state after reset");

   // program bytes stream out as they arrive, wrapping inside the page; op_start commits them
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         prog_valid_o <= 1'b0;
         prog_o       <= '0;
      end else if (ce_i) begin
         prog_valid_o <= 1'b0;
         if (sck_rise && state_reg == ST_ACTIVE && cmd_reg == CMD_PROG &&
             bit_cnt_reg >= `SFC_LEN_ADDR && bit_cnt_reg[2:0] == 3'h7) begin
            prog_valid_o <= 1'b1;
            prog_o.data  <= cmd_byte;
            prog_o.addr  <= (addr_reg & `SFC_PAGE_MASK) |
                            {11'h000, addr_reg[7:0] + bit_cnt_reg[10:3] - 8'h04}; // [R6]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         hw_lock_reg <= 1'b0;
         last_reg    <= 8'h00;
         reg_rdata_o <= 32'h0000_0000;
      end else if (ce_i) begin
         if (reg_wr_i && reg_addr_i == `SFC_REG_CTRL) hw_lock_reg <= reg_wdata_i[0];
         if (sck_rise && state_reg == ST_CMD && bit_cnt_reg == `SFC_LEN_CMD - 16'h0001 && accept)
            last_reg <= cmd_byte;
         reg_rdata_o <= 32'h0000_0000;
         if (reg_rd_i) begin
            case (reg_addr_i)
               `SFC_REG_STATUS: reg_rdata_o <= {26'h000_0000, deep_reg, status_byte[4:0]};
               `SFC_REG_CTRL:   reg_rdata_o <= {31'h0000_0000, hw_lock_reg};
               `SFC_REG_LAST:   reg_rdata_o <= {24'h00_0000, last_reg};
               default:         reg_rdata_o <= 32'h0000_0000;
            endcase
         end
      end
   end
   // sampling limits the serial clock to about a quarter of clk_i, well under 75 MHz / 70 MHz [R3]
endmodule : sfc_flash_if

/* File: design/sfc_pin_sync.sv */
`timescale 1ns/10ps
module sfc_pin_sync #(parameter int W = 4) (
   input  wire logic         clk_i,
   input  wire logic         arst_n_i,
   input  wire logic         ce_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o,
   output logic      [W-1:0] rise_o,
   output logic      [W-1:0] fall_o
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] sync_reg;
   logic [W-1:0] prev_reg;
   // reset to all ones: chip select idles high, clock edges are judged by change only
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta_reg <= '1;
         sync_reg <= '1;
         prev_reg <= '1;
      end else if (ce_i) begin
         meta_reg <= d_i;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end
   assign q_o    = sync_reg;
   assign rise_o = sync_reg & ~prev_reg & {W{ce_i}};
   assign fall_o = ~sync_reg & prev_reg & {W{ce_i}};
endmodule : sfc_pin_sync

/* File: pkg/sfc_params.svh */
`ifndef SFC_PARAMS_SVH
`define SFC_PARAMS_SVH
// command codes
`define SFC_OP_SETWL 8'h06
`define SFC_OP_CLRWL 8'h04
`define SFC_OP_STWR  8'h01
`define SFC_OP_STRD  8'h05
`define SFC_OP_IDRD  8'h9F
`define SFC_OP_READ  8'h03
`define SFC_OP_FAST  8'h0B
`define SFC_OP_SFDP  8'h5A
`define SFC_OP_DUAL  8'h3B
`define SFC_OP_SIG   8'hAB
`define SFC_OP_MKID  8'h90
`define SFC_OP_SECT  8'h20
`define SFC_OP_BE1   8'h52
`define SFC_OP_BE2   8'hD8
`define SFC_OP_CE1   8'h60
`define SFC_OP_CE2   8'hC7
`define SFC_OP_PROG  8'h02
`define SFC_OP_SLEEP 8'hB9
// frame lengths in serial clocks
`define SFC_LEN_CMD  16'h0008
`define SFC_LEN_STAT 16'h0010
`define SFC_LEN_ADDR 16'h0020
`define SFC_LEN_DUMY 16'h0028
// array organisation
`define SFC_SECT_MASK 19'h7_F000
`define SFC_BLK_MASK  19'h7_0000
`define SFC_PAGE_MASK 19'h7_FF00
`define SFC_SFDP_FILL 8'hFF
// register map
`define SFC_REG_STATUS 4'h0
`define SFC_REG_CTRL   4'h4
`define SFC_REG_LAST   4'h8
// timing, microseconds at the core clock rate
`define SFC_CLK_MHZ    100
`define SFC_T_PROG_US  1000
`define SFC_T_STAT_US  1000
`define SFC_T_SECT_US  40000
`define SFC_T_BLK_US   400000
`define SFC_T_CE_US    4000000
`endif

/* File: pkg/sfc_pkg.sv */
package sfc_pkg;
   typedef enum logic [1:0] {ST_STANDBY, ST_CMD, ST_ACTIVE, ST_IGNORE} sfc_state_t;
   typedef enum logic [4:0] {
      CMD_NONE, CMD_SETWL, CMD_CLRWL, CMD_STWR, CMD_STRD, CMD_IDRD, CMD_READ, CMD_FAST,
      CMD_SFDP, CMD_DUAL, CMD_SIG, CMD_MKID, CMD_SECT, CMD_BLK, CMD_CE, CMD_PROG, CMD_SLEEP
   } sfc_cmd_t;
   typedef enum logic [1:0] {OP_PROG, OP_STAT, OP_ERASE_SECT, OP_ERASE_BLK} sfc_op_kind_t;
   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic lane0;
      logic lane1;
   } sfc_pins_t;
   typedef struct packed {
      sfc_op_kind_t kind;
      logic         chip;
      logic [18:0]  addr;
   } sfc_op_t;
   typedef struct packed {
      logic [18:0] addr;
      logic [7:0]  data;
   } sfc_prog_t;
endpackage : sfc_pkg

/* File: testbench/sfc_host_model.sv */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////
module sfc_host_model
   import sfc_pkg::*;
(
   input  wire logic lane1_o,
   input  wire logic lane1_oe_n_i,
   output sfc_pins_t pins_o
);
   initial pins_o = 4'b1010;
   // one frame; idle picks the clock rest level, mode 0 or mode 3
   task automatic frame(input logic [39:0] tx, input int nb, input int nr, input logic idle,
                        output logic [7:0] rx);
      rx = 8'h00;
      // clock settles at its rest level before select, as a real host changes mode
      pins_o.sclk = idle;
      #62.5 pins_o.cs_n = 1'b0;
      #62.5;
      for (int i = 0; i < nb + nr; i++) begin
         pins_o.sclk = 1'b0;
         pins_o.lane0 = (i < nb) ? tx[nb-1-i] : ~pins_o.lane0;
         pins_o.lane1 = ~pins_o.lane0;
         #62.5 pins_o.sclk = 1'b1;
         // a released lane reads back inverted, so a late or missing enable shows up
         if (i >= nb) rx = {rx[6:0], lane1_oe_n_i ? ~lane1_o : lane1_o};
         #62.5;
      end
      pins_o.sclk = idle;
      // deselect after nb + nr clocks, whole bytes or not
      #62.5 pins_o.cs_n = 1'b1;
      pins_o.lane0 = ~pins_o.lane0;
      #250;
   endtask : frame
endmodule : sfc_host_model

/* File: testbench/tb_top.sv */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////
module tb_top;
   import sfc_pkg::*;
   localparam logic [7:0] SIG = 8'h6B; // arbitrary value
   logic clk_i = 0, arst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, lane1_o, oe1_n, busy_o, op_start_o, so_on = 0;
   logic mode3 = 0, ce = 1, prog_v;
   logic [18:0] mem_addr;
   sfc_prog_t   prog_w, prog_seen;
   int          prog_n = 0;
   logic [3:0]  reg_addr_i = 4'h0;
   logic [31:0] reg_wdata_i = 32'h0000_0000, reg_rdata_o, st;
   logic [7:0]  rx;
   sfc_pins_t   pins;
   sfc_op_t     op_o, op_seen;
   int          n_errors = 0, check_count = 0, ops = 0;
   always #5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      if (op_start_o === 1'b1) begin
         ops <= ops + 1;
         op_seen <= op_o;
      end
      if (oe1_n === 1'b0) so_on <= 1'b1;
      if (prog_v === 1'b1) begin
         prog_n <= prog_n + 1;
         prog_seen <= prog_w;
      end
   end
   sfc_host_model host (.lane1_o(lane1_o), .lane1_oe_n_i(oe1_n), .pins_o(pins));
   // array model: each byte holds its low address bits scrambled by a fixed pattern
   sfc_flash_if #(.PROG_CYC(40), .STAT_CYC(40), .SECT_CYC(2000), .BLK_CYC(40), .CE_CYC(40), .SIG_ID(SIG)) dut (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce), .pins_i(pins), .lane0_o(), .lane0_oe_n_o(),
      .lane1_o(lane1_o), .lane1_oe_n_o(oe1_n), .mem_addr_o(mem_addr), .mem_rdata_i(mem_addr[7:0] ^ 8'h5A),
      .op_start_o(op_start_o),
      .op_o(op_o), .prog_valid_o(prog_v), .prog_o(prog_w), .busy_o(busy_o), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));
   ////////////////////////////////////////////////////////////////
   task automatic stop_test;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : stop_test
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic spi(input logic [39:0] tx, input int nb, input int nr);
      host.frame(tx, nb, nr, mode3, rx);
   endtask : spi
   task automatic rd_reg(input logic [3:0] a);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      #1 st = reg_rdata_o;
   endtask : rd_reg
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask : wr_reg
   task automatic wait_idle;
      for (int i = 0; i < 3000 && busy_o !== 1'b0; i++) @(posedge clk_i);
      if (busy_o !== 1'b0) begin
         n_errors++;
         stop_test();
      end
   endtask : wait_idle
   ////////////////////////////////////////////////////////////////
   task automatic t_reset;
      check(busy_o, 1'b0);
      rd_reg(4'h0);
      check(st, 32'h0000_0000);
      rd_reg(4'hC);
      check(st, 32'h0000_0000);
   endtask : t_reset
   task automatic t_latch;
      spi(40'h06, 8, 0);
      rd_reg(4'h0);
      check(st[1], 1'b1);
      mode3 = 1;
      spi(40'h05, 8, 8);
      check(rx, 8'h02);
      mode3 = 0;
      spi(40'h04, 8, 0);
      rd_reg(4'h0);
      check(st[1], 1'b0);
   endtask : t_latch
   task automatic t_refuse;
      so_on = 0;
      spi(40'hFF, 8, 8);
      check(so_on, 1'b0);
      spi(40'h20_01_00_00, 32, 0);
      check(ops, 0);
      spi(40'h06, 8, 0);
      spi(40'h10_00_80_00, 31, 0);
      check(ops, 0);
   endtask : t_refuse
   task automatic t_erase;
      spi(40'h06, 8, 0);
      spi(40'h20_01_23_45, 32, 0);
      check(ops, 1);
      check(op_seen.addr, 19'h1_2000);
      check(op_seen.kind, OP_ERASE_SECT);
      check(busy_o, 1'b1);
      so_on = 0;
      spi(40'h03_00_00_00, 32, 8);
      check(so_on, 1'b0);
      check(ops, 1);
      wait_idle();
      rd_reg(4'h0);
      check(st[1], 1'b0);
      spi(40'h06, 8, 0);
      spi(40'h52_03_45_67, 32, 0);
      check(op_seen.addr, 19'h3_0000);
      check(op_seen.kind, OP_ERASE_BLK);
      wait_idle();
   endtask : t_erase
   task automatic t_sleep;
      spi(40'hB9, 8, 0);
      spi(40'h06, 8, 0);
      rd_reg(4'h0);
      check(st[5:1], 5'b1_0000);
      spi(40'hAB_00_00_00, 32, 8);
      check(rx, SIG);
      rd_reg(4'h0);
      check(st[5], 1'b0);
      rd_reg(4'h8);
      check(st, 32'h0000_00AB);
   endtask : t_sleep
   task automatic t_protect;
      wr_reg(4'h4, 32'h0000_0001);
      spi(40'h06, 8, 0);
      spi(40'h01_1C, 16, 0);
      wait_idle();
      rd_reg(4'h0);
      check(st[4:2], 3'h0);
      wr_reg(4'h4, 32'h0000_0000);
      spi(40'h06, 8, 0);
      spi(40'h01_04, 16, 0);
      wait_idle();
      rd_reg(4'h0);
      check(st[4:1], 4'b0010);
      spi(40'h06, 8, 0);
      spi(40'h20_07_00_00, 32, 0);
      check(ops, 4);
   endtask : t_protect
   task automatic t_data;
      spi(40'h03_00_00_10, 32, 8);
      check(rx, 8'h4A);
      spi(40'h06, 8, 0);
      // the target sector was erased earlier in the run
      spi(40'h02_01_23_10_A5, 40, 0);
      check(ops, 5);
      check(op_seen.kind, OP_PROG);
      check(op_seen.addr, 19'h1_2310);
      check(prog_n, 1);
      check(prog_seen, {19'h1_2310, 8'hA5});
      wait_idle();
      ce <= 1'b0;
      wr_reg(4'h4, 32'h0000_0001);
      ce <= 1'b1;
      rd_reg(4'h4);
      check(st, 32'h0000_0000);
   endtask : t_data
   initial begin
      repeat (20) @(posedge clk_i);
      arst_n_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      t_reset();
      t_latch();
      t_refuse();
      t_erase();
      t_sleep();
      t_protect();
      t_data();
      stop_test();
   end
endmodule : tb_top
